// file: rtl/udc_device.sv
// device end: endpoint handshakes, device state, suspend and resume
// Notes on behaviour
// - zero-length out is acked, sets bank0 flag
// - zero-length out reads count zero, irq pending
// - software clears bank0 flag to end status
// - force-stall request answers in and out with stall; setup still acked
// - stall sent sets sticky flag, irq pending
// - software picks functional or protocol stall
// - software clears stall flag on later setup
// - state changes only on bus or endpoint 0
// - idle bus enters suspend; host resume accepted
// - end of bus reset sets unmaskable flag
// - software enables endpoint 0 after reset
// - software applies address after status in
// - address state needs enable, address, function enable
// - software enables configured endpoints
// - idle bus sets suspend flag, masked irq
// - clear register clears suspend flag
// - resume detection independent of bus clock
// - bus resume sets resume flag, clearable
// - external resume event with enable sets flag
// - k-state driven only with remote-wake bit
`timescale 1ns/1ns
`default_nettype none
module udc_device #(
    parameter int unsigned SUSPEND_CYCLES = udc_pkg::SUSPEND_IDLE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // usb link
    udc_link_if.dev link,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    // interrupt and pins
    output logic irq,
    input wire logic ext_resume
);
    import udc_pkg::*;

    localparam int unsigned CNT_W = $clog2(SUSPEND_CYCLES + 1);

    typedef struct packed {
        logic [EP_NUM-1:0] ep_en;
        logic [EP_NUM-1:0] tx_comp;
        logic [EP_NUM-1:0] rx_full;
        logic [EP_NUM-1:0] stall_sent;
        logic [EP_NUM-1:0] force_stall;
        logic [EP_NUM-1:0] tx_ready;
        logic [EP_NUM-1:0][2:0] ep_type;
        logic [EP_NUM-1:0][LEN_W-1:0] byte_cnt;
        logic addr_state;
        logic configured;
        logic send_resume_en;
        logic resume_seen;
        logic remote_wake;
        logic function_enable_bit;
        logic [6:0] faddr;
        logic [IRQ_W-1:0] imr;
        logic suspend_f;
        logic resume_f;
        logic reset_end_f;
        logic sof_f;
        logic suspended;
        logic [CNT_W-1:0] idle_cnt;
        logic in_reset;
        logic [2:0] ext_sync;
        logic hs_valid;
        udc_hs_t hs_code;
        logic k_drive;
        logic irq;
        logic [31:0] rdata;
        logic ack;
    } udc_dev_state_t;

    udc_dev_state_t s_q, s_d;

    function automatic logic [IRQ_W-1:0] status_of(input udc_dev_state_t s);
        logic [IRQ_W-1:0] v;
        v = '0;
        v[EP_NUM-1:0] = s.rx_full | s.stall_sent | s.tx_comp;
        v[IRQ_SUSPEND] = s.suspend_f;
        v[IRQ_RESUME] = s.resume_f;
        v[IRQ_SOF] = s.sof_f;
        v[IRQ_BUS_RESET_END] = s.reset_end_f;
        return v;
    endfunction : status_of

    always_comb begin
        logic [2:0] ep;
        logic [IRQ_W-1:0] clr;
        logic [6:0] my_addr;
        logic hit;
        logic activity;
        logic ext_rise;
        s_d = s_q;
        ep = link.pkt_ep[2:0];
        clr = '0;
        my_addr = s_q.function_enable_bit ? s_q.faddr : FADDR_RESET;
        hit = link.pkt_valid && !s_q.in_reset && !link.bus_reset && link.pkt_addr == my_addr
              && link.pkt_ep < 4'(EP_NUM) && s_q.ep_en[ep];
        activity = link.pkt_valid || link.bus_reset || link.host_resume;
        // only the later two flops are compared; the first merely resolves metastability
        s_d.ext_sync = {s_q.ext_sync[1:0], ext_resume};
        ext_rise = s_q.ext_sync[1] && !s_q.ext_sync[2];
        s_d.hs_valid = 1'b0;
        s_d.ack = 1'b0;
        s_d.rdata = '0;

        // software side: writes first, so hardware sets below win over clears
        if (reg_wr) begin
            if (reg_addr == OFF_GLB_STATE) begin
                if (reg_wdata[GLB_ADDR_STATE]) begin
                    s_d.addr_state = 1'b1;
                end
                s_d.configured = reg_wdata[GLB_CONFIGURED];
                s_d.send_resume_en = reg_wdata[GLB_SEND_RESUME];
                s_d.remote_wake = reg_wdata[GLB_REMOTE_WAKE];
            end else if (reg_addr == OFF_FUNC_ADDR) begin
                s_d.faddr = reg_wdata[6:0];
                s_d.function_enable_bit = reg_wdata[FADDR_FEN];
            end else if (reg_addr == OFF_IRQ_ENABLE) begin
                s_d.imr = s_q.imr | reg_wdata[IRQ_W-1:0];
            end else if (reg_addr == OFF_IRQ_DISABLE) begin
                s_d.imr = s_q.imr & ~reg_wdata[IRQ_W-1:0];
            end else if (reg_addr == OFF_IRQ_CLEAR) begin
                clr = reg_wdata[IRQ_W-1:0];
            end else if (reg_addr >= OFF_EP_CSR0 && reg_addr <= OFF_EP_CSR_LAST
                         && reg_addr[1:0] == 2'b00) begin
                ep = 3'(reg_addr[7:2] - OFF_EP_CSR0[7:2]);
                // event flags: writing zero clears, writing one leaves them alone
                s_d.tx_comp[ep] = s_q.tx_comp[ep] & reg_wdata[CSR_TX_COMPLETE];
                s_d.rx_full[ep] = s_q.rx_full[ep] & reg_wdata[CSR_RX_BANK0];
                s_d.stall_sent[ep] = s_q.stall_sent[ep] & reg_wdata[CSR_STALL_SENT];
                s_d.tx_ready[ep] = reg_wdata[CSR_TX_READY];
                s_d.force_stall[ep] = reg_wdata[CSR_FORCE_STALL];
                s_d.ep_type[ep] = reg_wdata[CSR_TYPE_LO +: 3];
                s_d.ep_en[ep] = reg_wdata[CSR_ENABLE];
            end
        end
        s_d.suspend_f = s_q.suspend_f & ~clr[IRQ_SUSPEND];
        s_d.resume_f = s_q.resume_f & ~clr[IRQ_RESUME];
        s_d.sof_f = s_q.sof_f & ~clr[IRQ_SOF];
        s_d.reset_end_f = s_q.reset_end_f & ~clr[IRQ_BUS_RESET_END];

        // link side
        ep = link.pkt_ep[2:0];
        if (hit) begin
            s_d.hs_valid = link.pkt_kind != PKT_SOF;
            unique case (link.pkt_kind)
                PKT_SETUP: begin
                    s_d.hs_code = HS_ACK;
                    s_d.rx_full[ep] = 1'b1;
                    s_d.byte_cnt[ep] = link.pkt_len;
                end
                PKT_OUT: begin
                    if (s_q.force_stall[ep]) begin
                        s_d.hs_code = HS_STALL;
                        s_d.stall_sent[ep] = 1'b1;
                    end else if (s_q.rx_full[ep]) begin
                        s_d.hs_code = HS_NAK;
                    end else begin
                        s_d.hs_code = HS_ACK;
                        s_d.rx_full[ep] = 1'b1;
                        s_d.byte_cnt[ep] = link.pkt_len;
                    end
                end
                PKT_IN: begin
                    if (s_q.force_stall[ep]) begin
                        s_d.hs_code = HS_STALL;
                        s_d.stall_sent[ep] = 1'b1;
                    end else if (s_q.tx_ready[ep]) begin
                        s_d.hs_code = HS_ACK;
                        s_d.tx_ready[ep] = 1'b0;
                        s_d.tx_comp[ep] = 1'b1;
                    end else begin
                        s_d.hs_code = HS_NAK;
                    end
                end
                PKT_SOF: begin
                    s_d.sof_f = 1'b1;
                end
            endcase
        end else if (link.pkt_valid && link.pkt_kind == PKT_SOF && !s_q.in_reset) begin
            s_d.sof_f = 1'b1;
        end

        // bus reset returns the device to default state
        s_d.in_reset = link.bus_reset;
        if (link.bus_reset) begin
            s_d.ep_en = '0;
            s_d.addr_state = 1'b0;
            s_d.configured = 1'b0;
            s_d.function_enable_bit = 1'b0;
            s_d.faddr = FADDR_RESET;
        end else if (s_q.in_reset) begin
            s_d.reset_end_f = 1'b1;
        end

        // suspend on a quiet bus; any activity restarts the count
        if (activity) begin
            s_d.idle_cnt = '0;
        end else if (!s_q.suspended && s_q.idle_cnt != CNT_W'(SUSPEND_CYCLES)) begin
            s_d.idle_cnt = s_q.idle_cnt + 1'b1;
        end
        if (!s_q.suspended && !activity && s_q.idle_cnt == CNT_W'(SUSPEND_CYCLES - 1)) begin
            s_d.suspend_f = 1'b1;
            s_d.suspended = 1'b1;
        end
        if (s_q.suspended && activity) begin
            s_d.resume_f = 1'b1;
            s_d.suspended = 1'b0;
            s_d.idle_cnt = '0;
            if (s_q.k_drive && link.host_resume) begin
                s_d.resume_seen = 1'b1;
            end
        end
        if (s_q.send_resume_en && ext_rise) begin
            s_d.resume_f = 1'b1;
        end
        s_d.k_drive = s_q.suspended && s_q.send_resume_en && s_q.remote_wake;
        if (link.pkt_valid && !s_q.suspended) begin
            s_d.resume_seen = 1'b0;
        end

        // read port; unmapped offsets read as zero
        if (reg_rd) begin
            s_d.ack = 1'b1;
            if (reg_addr == OFF_GLB_STATE) begin
                s_d.rdata[GLB_ADDR_STATE] = s_q.addr_state;
                s_d.rdata[GLB_CONFIGURED] = s_q.configured;
                s_d.rdata[GLB_SEND_RESUME] = s_q.send_resume_en;
                s_d.rdata[GLB_RESUME_SEEN] = s_q.resume_seen;
                s_d.rdata[GLB_REMOTE_WAKE] = s_q.remote_wake;
            end else if (reg_addr == OFF_FUNC_ADDR) begin
                s_d.rdata[6:0] = s_q.faddr;
                s_d.rdata[FADDR_FEN] = s_q.function_enable_bit;
            end else if (reg_addr == OFF_IRQ_MASK) begin
                s_d.rdata[IRQ_W-1:0] = s_q.imr;
            end else if (reg_addr == OFF_IRQ_STATUS) begin
                s_d.rdata[IRQ_W-1:0] = status_of(s_q);
            end else if (reg_addr >= OFF_EP_CSR0 && reg_addr <= OFF_EP_CSR_LAST
                         && reg_addr[1:0] == 2'b00) begin
                ep = 3'(reg_addr[7:2] - OFF_EP_CSR0[7:2]);
                s_d.rdata[CSR_TX_COMPLETE] = s_q.tx_comp[ep];
                s_d.rdata[CSR_RX_BANK0] = s_q.rx_full[ep];
                s_d.rdata[CSR_STALL_SENT] = s_q.stall_sent[ep];
                s_d.rdata[CSR_TX_READY] = s_q.tx_ready[ep];
                s_d.rdata[CSR_FORCE_STALL] = s_q.force_stall[ep];
                s_d.rdata[CSR_TYPE_LO +: 3] = s_q.ep_type[ep];
                s_d.rdata[CSR_ENABLE] = s_q.ep_en[ep];
                s_d.rdata[CSR_COUNT_LO +: LEN_W] = s_q.byte_cnt[ep];
            end
        end

        // end-of-reset flag bypasses the mask
        s_d.irq = |(status_of(s_d) & s_d.imr) || s_d.reset_end_f;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.imr <= IMR_RESET;
            s_q.function_enable_bit <= FEN_RESET;
            s_q.faddr <= FADDR_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.hs_valid = s_q.hs_valid;
    assign link.hs_code = s_q.hs_code;
    assign link.dev_k_state = s_q.k_drive;
    assign reg_rdata = s_q.rdata;
    assign reg_ack = s_q.ack;
    assign irq = s_q.irq;
endmodule : udc_device
`default_nettype wire

// file: rtl/udc_host.sv
// host end: issues packets, bus reset and resume signalling on the link
`timescale 1ns/1ns
`default_nettype none
module udc_host #(
    parameter int unsigned RESUME_CYCLES = udc_pkg::RESUME_K_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // usb link
    udc_link_if.host link,
    // packet requests
    input wire logic cmd_valid,
    input wire udc_pkg::udc_pkt_t cmd_kind,
    input wire logic [6:0] cmd_addr,
    input wire logic [3:0] cmd_ep,
    input wire logic [udc_pkg::LEN_W-1:0] cmd_len,
    output logic cmd_ready,
    // answers
    output logic rsp_valid,
    output udc_pkg::udc_hs_t rsp_code,
    // bus conditions
    input wire logic reset_req,
    input wire logic resume_req,
    output logic k_seen
);
    import udc_pkg::*;

    localparam int unsigned RCNT_W = $clog2(RESUME_CYCLES + 1);

    typedef enum {
        ST_IDLE,
        ST_WAIT,
        ST_ANSWER
    } udc_host_st_t;

    typedef struct packed {
        udc_host_st_t st;
        logic pkt_valid;
        udc_pkt_t kind;
        logic [6:0] addr;
        logic [3:0] ep;
        logic [LEN_W-1:0] len;
        logic bus_reset;
        logic resume;
        logic [RCNT_W-1:0] rcnt;
        logic ready;
        logic rsp_valid;
        udc_hs_t rsp_code;
        logic k_seen;
    } udc_host_state_t;

    udc_host_state_t h_q, h_d;

    always_comb begin
        h_d = h_q;
        h_d.pkt_valid = 1'b0;
        h_d.rsp_valid = 1'b0;
        h_d.bus_reset = reset_req;
        h_d.k_seen = link.dev_k_state;
        // the device answers in the cycle after the packet; a missed answer never stalls
        case (h_q.st)
            ST_IDLE: begin
                if (cmd_valid && h_q.ready && !reset_req) begin
                    h_d.pkt_valid = 1'b1;
                    h_d.kind = cmd_kind;
                    h_d.addr = cmd_addr;
                    h_d.ep = cmd_ep;
                    h_d.len = cmd_len;
                    h_d.ready = 1'b0;
                    h_d.st = ST_WAIT;
                end
            end
            // the handshake launches on the edge after the packet, so look one edge later
            ST_WAIT: begin
                h_d.st = ST_ANSWER;
            end
            ST_ANSWER: begin
                h_d.st = ST_IDLE;
                h_d.ready = 1'b1;
                if (link.hs_valid) begin
                    h_d.rsp_valid = 1'b1;
                    h_d.rsp_code = link.hs_code;
                end
            end
            default: h_d.st = ST_IDLE;
        endcase
        if (resume_req && !h_q.resume) begin
            h_d.resume = 1'b1;
            h_d.rcnt = RCNT_W'(RESUME_CYCLES - 1);
        end else if (h_q.resume) begin
            if (h_q.rcnt == '0) begin
                h_d.resume = 1'b0;
            end else begin
                h_d.rcnt = h_q.rcnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            h_q <= '0;
            h_q.st <= ST_IDLE;
            h_q.ready <= 1'b1;
        end else begin
            h_q <= h_d;
        end
    end

    assign link.pkt_valid = h_q.pkt_valid;
    assign link.pkt_kind = h_q.kind;
    assign link.pkt_addr = h_q.addr;
    assign link.pkt_ep = h_q.ep;
    assign link.pkt_len = h_q.len;
    assign link.bus_reset = h_q.bus_reset;
    assign link.host_resume = h_q.resume;
    assign cmd_ready = h_q.ready;
    assign rsp_valid = h_q.rsp_valid;
    assign rsp_code = h_q.rsp_code;
    assign k_seen = h_q.k_seen;
endmodule : udc_host
`default_nettype wire

// file: rtl/udc_link_if.sv
// abstracted usb link between the host end and the device end
`timescale 1ns/1ns
`default_nettype none
interface udc_link_if;
    import udc_pkg::*;
    logic pkt_valid;
    udc_pkt_t pkt_kind;
    logic [6:0] pkt_addr;
    logic [3:0] pkt_ep;
    logic [LEN_W-1:0] pkt_len;
    logic bus_reset;
    logic host_resume;
    logic hs_valid;
    udc_hs_t hs_code;
    logic dev_k_state;
    modport host (output pkt_valid, pkt_kind, pkt_addr, pkt_ep, pkt_len, bus_reset,
                  host_resume, input hs_valid, hs_code, dev_k_state);
    modport dev (input pkt_valid, pkt_kind, pkt_addr, pkt_ep, pkt_len, bus_reset,
                 host_resume, output hs_valid, hs_code, dev_k_state);
endinterface : udc_link_if
`default_nettype wire

// file: rtl/udc_pkg.sv
// shared constants of the usb control-endpoint and device-state logic
package udc_pkg;
    localparam int unsigned EP_NUM = 8;
    localparam int unsigned LEN_W = 11;
    localparam logic [7:0] OFF_GLB_STATE = 8'h04;
    localparam logic [7:0] OFF_FUNC_ADDR = 8'h08;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFF_IRQ_DISABLE = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h20;
    localparam logic [7:0] OFF_EP_CSR0 = 8'h30;
    localparam logic [7:0] OFF_EP_CSR_LAST = 8'h4c;
    // global state bits
    localparam int unsigned GLB_ADDR_STATE = 0;
    localparam int unsigned GLB_CONFIGURED = 1;
    localparam int unsigned GLB_SEND_RESUME = 2;
    localparam int unsigned GLB_RESUME_SEEN = 3;
    localparam int unsigned GLB_REMOTE_WAKE = 4;
    // function address register
    localparam int unsigned FADDR_FEN = 8;
    localparam logic [6:0] FADDR_RESET = 7'h00;
    localparam logic FEN_RESET = 1'b1;
    // interrupt bit positions: endpoints occupy the low EP_NUM bits
    localparam int unsigned IRQ_SUSPEND = 8;
    localparam int unsigned IRQ_RESUME = 9;
    localparam int unsigned IRQ_SOF = 11;
    localparam int unsigned IRQ_BUS_RESET_END = 12;
    localparam int unsigned IRQ_W = 13;
    localparam logic [12:0] IMR_RESET = 13'h1200;
    // endpoint control/status fields
    localparam int unsigned CSR_TX_COMPLETE = 0;
    localparam int unsigned CSR_RX_BANK0 = 1;
    localparam int unsigned CSR_STALL_SENT = 3;
    localparam int unsigned CSR_TX_READY = 4;
    localparam int unsigned CSR_FORCE_STALL = 5;
    localparam int unsigned CSR_TYPE_LO = 8;
    localparam int unsigned CSR_ENABLE = 15;
    localparam int unsigned CSR_COUNT_LO = 16;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned SUSPEND_IDLE_NS = 3000000;
    localparam int unsigned SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_NS / CLK_PERIOD_NS;
    localparam int unsigned RESUME_K_NS = 20000000;
    localparam int unsigned RESUME_K_CYCLES = RESUME_K_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        PKT_SETUP,
        PKT_OUT,
        PKT_IN,
        PKT_SOF
    } udc_pkt_t;
    typedef enum logic [1:0] {
        HS_ACK,
        HS_NAK,
        HS_STALL
    } udc_hs_t;
endpackage : udc_pkg

// file: tb/udc_checker.sv
// concurrent checks on the link between the host end and the device end
`timescale 1ns/1ns
`default_nettype none
module udc_checker #(
    parameter int unsigned SUSPEND_CYCLES = 50,
    parameter int unsigned RESUME_CYCLES = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host to device
    input wire logic pkt_valid,
    input wire udc_pkg::udc_pkt_t pkt_kind,
    input wire logic [6:0] pkt_addr,
    input wire logic [3:0] pkt_ep,
    input wire logic [udc_pkg::LEN_W-1:0] pkt_len,
    input wire logic bus_reset,
    input wire logic host_resume,
    // device to host
    input wire logic hs_valid,
    input wire udc_pkg::udc_hs_t hs_code,
    input wire logic dev_k_state
);
    import udc_pkg::*;
    logic [31:0] idle_q;
    logic [31:0] res_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // idle and host-resume run lengths, so remote wake can be tied to a quiet bus and resume length checked
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idle_q <= '0;
            res_q <= '0;
        end else begin
            idle_q <= (pkt_valid || bus_reset || host_resume) ? '0 : idle_q + 32'h1;
            res_q <= host_resume ? res_q + 32'h1 : '0;
        end
    end
    AST_HS_AFTER_PKT: assert property (hs_valid |-> $past(pkt_valid))
        else $error("handshake without a packet one cycle before");
    AST_HS_PULSE: assert property (hs_valid |=> !hs_valid)
        else $error("handshake longer than one cycle");
    AST_SOF_SILENT: assert property (pkt_valid && pkt_kind == PKT_SOF |=> !hs_valid)
        else $error("start of frame answered");
    AST_SETUP_ACK: assert property ((pkt_valid && pkt_kind == PKT_SETUP) ##1 hs_valid
        |-> hs_code == HS_ACK)
        else $error("setup not acked");
    AST_RESET_SILENT: assert property (pkt_valid && bus_reset |=> !hs_valid)
        else $error("packet answered in bus reset");
    AST_EP_RANGE: assert property (pkt_valid && pkt_ep > 4'h7 |=> !hs_valid)
        else $error("absent endpoint answered");
    AST_K_SUSPENDED: assert property ($rose(dev_k_state) |-> idle_q >= SUSPEND_CYCLES)
        else $error("remote wake driven on a busy bus");
    AST_RESUME_LEN: assert property ($fell(host_resume) |-> res_q == RESUME_CYCLES)
        else $error("host resume of wrong length");
endmodule : udc_checker
`default_nettype wire

// file: tb/usb_device_ctrl_state_tb.sv
// self-checking bench: host end and device end joined on one link
`timescale 1ns/1ns
`default_nettype none
module usb_device_ctrl_state_tb;
    import udc_pkg::*;
    localparam int unsigned SUSP = 50;
    localparam int unsigned RES = 20;
    localparam logic [2:0] H_NONE = 3'h0;
    localparam logic [2:0] H_ACK = {1'h1, HS_ACK};
    localparam logic [2:0] H_NAK = {1'h1, HS_NAK};
    localparam logic [2:0] H_STALL = {1'h1, HS_STALL};
    logic clk = '0;
    logic rst_n = '0;
    logic reg_wr = '0;
    logic reg_rd = '0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic [31:0] reg_rdata;
    logic reg_ack;
    logic irq;
    logic ext_resume = '0;
    logic cmd_valid = '0;
    udc_pkt_t cmd_kind = PKT_SETUP;
    logic [6:0] cmd_addr = '0;
    logic [3:0] cmd_ep = '0;
    logic [LEN_W-1:0] cmd_len = '0;
    logic cmd_ready;
    logic rsp_valid;
    udc_hs_t rsp_code;
    logic reset_req = '0;
    logic resume_req = '0;
    logic k_seen;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 77286;
    logic [LEN_W-1:0] len;
    always #2 clk = ~clk;
    udc_link_if link ();
    udc_host #(.RESUME_CYCLES(RES)) i_udc_host (.clk(clk), .rst_n(rst_n), .link(link),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_ep(cmd_ep),
        .cmd_len(cmd_len), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_code(rsp_code),
        .reset_req(reset_req), .resume_req(resume_req), .k_seen(k_seen));
    udc_device #(.SUSPEND_CYCLES(SUSP)) i_udc_device (.clk(clk), .rst_n(rst_n), .link(link),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .irq(irq), .ext_resume(ext_resume));
    udc_checker #(.SUSPEND_CYCLES(SUSP), .RESUME_CYCLES(RES)) i_udc_checker (.clk(clk),
        .rst_n(rst_n), .pkt_valid(link.pkt_valid), .pkt_kind(link.pkt_kind),
        .pkt_addr(link.pkt_addr), .pkt_ep(link.pkt_ep), .pkt_len(link.pkt_len),
        .bus_reset(link.bus_reset), .host_resume(link.host_resume), .hs_valid(link.hs_valid),
        .hs_code(link.hs_code), .dev_k_state(link.dev_k_state));

    function automatic logic [31:0] csr(input logic [LEN_W-1:0] l);
        return {5'h00, l, 16'h8002};
    endfunction : csr

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(negedge clk);
        reg_wr = '0;
        @(negedge clk);
    endtask : wr

    // read, then compare the masked bits
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] m);
        logic [31:0] d;
        d = 32'hdead_beef;
        reg_addr = a;
        reg_rd = 1'h1;
        @(negedge clk);
        reg_rd = '0;
        for (int i = 0; i < 4; i++) begin
            if (reg_ack === 1'h1) begin
                d = reg_rdata;
                break;
            end
            @(negedge clk);
        end
        check(name, exp & m, d & m);
    endtask : rchk

    // one packet, then watch a bounded window for its handshake
    task automatic send(input udc_pkt_t k, input logic [6:0] a, input logic [3:0] e,
                        input logic [LEN_W-1:0] l, input logic [2:0] exp);
        logic [2:0] got;
        got = H_NONE;
        while (cmd_ready !== 1'h1) @(negedge clk);
        cmd_kind = k;
        cmd_addr = a;
        cmd_ep = e;
        cmd_len = l;
        cmd_valid = 1'h1;
        @(negedge clk);
        cmd_valid = '0;
        repeat (6) begin
            @(negedge clk);
            if (rsp_valid === 1'h1) got = {1'h1, rsp_code};
        end
        check("handshake", {29'h0, exp}, {29'h0, got});
    endtask : send

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            final_report;
        end
    end

    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        rchk("imr", OFF_IRQ_MASK, 32'h1200, '1);
        rchk("faddr", OFF_FUNC_ADDR, 32'h100, '1);
        rchk("isr", OFF_IRQ_STATUS, 32'h0, '1);
        reset_req = 1'h1;
        send(PKT_SETUP, 7'h00, 4'h0, 11'h008, H_NONE);
        reset_req = '0;
        repeat (4) @(negedge clk);
        rchk("isr", OFF_IRQ_STATUS, 32'h1000, 32'h1000);
        check("irq", 32'h1, {31'h0, irq});
        wr(OFF_IRQ_CLEAR, 32'h1000);
        $display("test bus reset done");
        send(PKT_OUT, 7'h00, 4'h0, 11'h004, H_NONE);
        wr(OFF_EP_CSR0, 32'h8000);
        send(PKT_SETUP, 7'h00, 4'h0, 11'h008, H_ACK);
        rchk("csr0", OFF_EP_CSR0, csr(11'h008), '1);
        wr(OFF_EP_CSR0, 32'h8000);
        send(PKT_OUT, 7'h00, 4'h0, 11'h000, H_ACK);
        rchk("csr0", OFF_EP_CSR0, csr(11'h000), '1);
        rchk("isr", OFF_IRQ_STATUS, 32'h1, 32'h1);
        send(PKT_OUT, 7'h00, 4'h0, 11'h005, H_NAK);
        wr(OFF_EP_CSR0, 32'h8000);
        rchk("isr", OFF_IRQ_STATUS, 32'h0, 32'h1);
        send(PKT_SOF, 7'h00, 4'h0, 11'h000, H_NONE);
        send(PKT_OUT, 7'h00, 4'h9, 11'h001, H_NONE);
        $display("test status out done");
        send(PKT_SETUP, 7'h05, 4'h0, 11'h008, H_NONE);
        wr(OFF_EP_CSR0, 32'h8010);
        send(PKT_IN, 7'h00, 4'h0, 11'h000, H_ACK);
        rchk("csr0", OFF_EP_CSR0, 32'h8001, 32'hffff);
        wr(OFF_EP_CSR0, 32'h8000);
        send(PKT_IN, 7'h00, 4'h0, 11'h000, H_NAK);
        wr(OFF_FUNC_ADDR, 32'h105);
        wr(OFF_GLB_STATE, 32'h1);
        rchk("glb", OFF_GLB_STATE, 32'h1, 32'h1);
        send(PKT_SETUP, 7'h05, 4'h0, 11'h008, H_ACK);
        send(PKT_SETUP, 7'h00, 4'h0, 11'h008, H_NONE);
        wr(OFF_GLB_STATE, 32'h3);
        wr(OFF_EP_CSR0 + 8'h04, 32'h8200);
        send(PKT_OUT, 7'h05, 4'h1, 11'h010, H_ACK);
        rchk("csr1", OFF_EP_CSR0 + 8'h04, csr(11'h010) | 32'h200, '1);
        wr(OFF_EP_CSR0, 32'h8020);
        send(PKT_OUT, 7'h05, 4'h0, 11'h003, H_STALL);
        rchk("csr0", OFF_EP_CSR0, 32'h8028, 32'hffff);
        rchk("isr", OFF_IRQ_STATUS, 32'h1, 32'h1);
        send(PKT_SETUP, 7'h05, 4'h0, 11'h008, H_ACK);
        wr(OFF_EP_CSR0, 32'h8000);
        rchk("isr", OFF_IRQ_STATUS, 32'h0, 32'h1);
        $display("test address and stall done");
        for (int i = 0; i < 6; i++) begin
            len = (i == 0) ? 11'h7ff : LEN_W'($random(seed));
            send(PKT_OUT, 7'h05, 4'h0, len, H_ACK);
            rchk("csr0", OFF_EP_CSR0, csr(len), '1);
            wr(OFF_EP_CSR0, 32'h8000);
        end
        $display("test random out done");
        repeat (SUSP + 10) @(negedge clk);
        rchk("isr", OFF_IRQ_STATUS, 32'h100, 32'h300);
        check("irq", 32'h0, {31'h0, irq});
        wr(OFF_IRQ_ENABLE, 32'h100);
        @(negedge clk);
        check("irq", 32'h1, {31'h0, irq});
        wr(OFF_IRQ_CLEAR, 32'h100);
        rchk("isr", OFF_IRQ_STATUS, 32'h0, 32'h100);
        resume_req = 1'h1;
        @(negedge clk);
        resume_req = '0;
        repeat (RES + 6) @(negedge clk);
        rchk("isr", OFF_IRQ_STATUS, 32'h200, 32'h200);
        wr(OFF_IRQ_CLEAR, 32'h200);
        rchk("isr", OFF_IRQ_STATUS, 32'h0, 32'h200);
        $display("test suspend and host resume done");
        wr(OFF_GLB_STATE, 32'h4);
        repeat (SUSP + 10) @(negedge clk);
        check("k_seen", 32'h0, {31'h0, k_seen});
        wr(OFF_GLB_STATE, 32'h15);
        repeat (3) @(negedge clk);
        check("k_seen", 32'h1, {31'h0, k_seen});
        ext_resume = 1'h1;
        repeat (4) @(negedge clk);
        ext_resume = '0;
        repeat (4) @(negedge clk);
        rchk("isr", OFF_IRQ_STATUS, 32'h200, 32'h200);
        $display("test remote wake done");
        final_report;
    end
endmodule : usb_device_ctrl_state_tb
`default_nettype wire
